// file: rtl/gauge_config_accounting.sv
// Configuration bytes of a single-cell gauge and the capacity accounting that uses them
//
// Notes on behaviour
// - Reset seeds the learned full capacity with the seed byte high and zero low.
// - The empty level in millivolts is (empty byte plus 256) times 8.
// - The low-warning level uses the same byte plus 256 times 8 scaling.
// - On reaching the low-warning level the learned capacity becomes discharge plus 6.25 % of the old learned capacity.
// - Learning is dropped if average current is at most twice the standby value then.
// - The standby byte counts sense voltage in 6 uV steps.
// - The deadband is the upper nibble in 6 uV steps, the self-discharge code the lower.
// - Self-discharge only acts while the battery is not charging.
// - The programmed code applies from 20 up to but not including 30 degrees.
// - Each 10 degree band hotter doubles the rate, up to sixteen times at 60 and above.
// - Each 10 degree band colder halves the rate, down to a quarter below 10 degrees.
// - One self-discharge step takes a 512th of the current available capacity.
// - Code 12 gives one step per 24 hours in the reference band, 12 hours one band up.
// - Full charge is voltage plus charge current under the taper byte times 192 uV.
// - Apart from reset, the learned capacity only changes at the low-warning edge with learning valid.
`timescale 1ns/1ps

module gauge_config_accounting #(
    parameter longint      HOUR_CYCLES    = gauge_pkg::HOUR_CYCLES,
    parameter logic [15:0] CHARGE_FULL_MV = 16'h1004
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire gauge_pkg::cfg_s   nv_cfg,
    input  wire logic [6:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    output logic [7:0]             reg_rdata,
    input  wire logic              charging,
    input  wire logic [15:0]       vbat_mv,
    input  wire logic [15:0]       avg_uv,
    input  wire logic [15:0]       charge_uv,
    input  wire logic signed [7:0] temp_c,
    input  wire gauge_pkg::flow_s  flow,
    output logic [15:0]            nominal_available_capacity,
    output logic [15:0]            learned_full_capacity,
    output gauge_pkg::status_s     status,
    output gauge_pkg::nv_write_s   nv_write
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (HOUR_CYCLES < 1 || HOUR_CYCLES >= (64'd1 << gauge_pkg::HOUR_W)) begin : g_chk
        $error("HOUR_CYCLES out of range");
    end

    // ****************************************
    // Functions
    // ****************************************
    // Scaled voltage byte to millivolts
    function automatic logic [15:0] level_mv(input logic [7:0] b);
        level_mv = (16'(b) + gauge_pkg::VOLT_OFFSET) << gauge_pkg::VOLT_SHIFT;
    endfunction

    // Rate weight in quarters of the programmed rate
    function automatic logic [6:0] band_weight(input logic signed [7:0] t);
        if (t >= gauge_pkg::T_60) begin
            band_weight = gauge_pkg::W_X16;
        end else if (t >= gauge_pkg::T_50) begin
            band_weight = gauge_pkg::W_X8;
        end else if (t >= gauge_pkg::T_40) begin
            band_weight = gauge_pkg::W_X4;
        end else if (t >= gauge_pkg::T_30) begin
            band_weight = gauge_pkg::W_X2;
        end else if (t >= gauge_pkg::T_20) begin
            band_weight = gauge_pkg::W_REF;
        end else if (t >= gauge_pkg::T_10) begin
            band_weight = gauge_pkg::W_HALF;
        end else begin
            band_weight = gauge_pkg::W_QUARTER;
        end
    endfunction

    // Subtract without wrapping below zero
    function automatic logic [15:0] sub_floor(input logic [15:0] a, input logic [15:0] b);
        sub_floor = (a > b) ? a - b : 16'h0000;
    endfunction

    // Add without wrapping past full scale
    function automatic logic [15:0] add_sat(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        add_sat = sum[16] ? 16'hffff : sum[15:0];
    endfunction

    // ****************************************
    // State and decoded thresholds
    // ****************************************
    gauge_pkg::state_s s_reg;
    gauge_pkg::state_s s_next;

    logic [15:0] empty_mv;
    logic [15:0] low_mv;
    logic [15:0] standby_lim;
    logic [15:0] deadband_uv;
    logic [15:0] taper_uv;
    logic [7:0]  filter_byte;
    logic [3:0]  self_discharge_code;
    logic [7:0]  step_limit;
    logic [6:0]  weight;
    logic        hour_tick;
    logic        flow_hit;
    logic        decay_step;
    logic        full_hit;
    logic        low_hit;
    logic        low_rise;
    logic        learn_ok;
    logic        learn_drop;
    logic        empty_hit;
    logic [15:0] learn_sum;
    logic [15:0] decay_cap;

    // Threshold scaling from the live configuration bytes
    assign empty_mv    = level_mv(s_reg.cfg.empty);
    assign low_mv      = level_mv(s_reg.cfg.low);
    assign standby_lim = 16'(s_reg.cfg.standby) * 16'(gauge_pkg::STANDBY_STEP_UV) * 16'h0002;
    // One byte carries both the deadband nibble and the decay code
    assign filter_byte = s_reg.cfg.deadband_and_self_discharge;
    assign deadband_uv = 16'(filter_byte[gauge_pkg::FILTER_MSB:gauge_pkg::FILTER_LSB])
                         * 16'(gauge_pkg::DEADBAND_STEP_UV);
    assign self_discharge_code = filter_byte[gauge_pkg::CODE_MSB:gauge_pkg::CODE_LSB];
    assign taper_uv    = 16'(s_reg.cfg.taper) * 16'(gauge_pkg::TAPER_STEP_UV);
    // Step interval in quarter-rate hours; code 12 at weight 4 needs 96
    assign step_limit  = 8'(self_discharge_code) * gauge_pkg::HOURS_PER_CODE
                         * 8'(gauge_pkg::W_REF);
    assign weight      = band_weight(temp_c);

    // Event decodes for this cycle
    assign hour_tick  = (s_reg.hour_cnt == gauge_pkg::HOUR_W'(HOUR_CYCLES - 1));
    assign flow_hit   = flow.valid && (flow.sense_uv >= deadband_uv);
    assign decay_step = hour_tick && !charging && (self_discharge_code != 4'h0)
                        && ((s_reg.decay_acc + gauge_pkg::DECAY_ACC_W'(weight))
                            >= step_limit);
    assign full_hit   = charging && (vbat_mv >= CHARGE_FULL_MV) && (charge_uv < taper_uv);
    assign low_hit    = !charging && (vbat_mv <= low_mv);
    assign low_rise   = low_hit && !s_reg.st.low_warning;
    assign learn_ok   = low_rise && s_reg.st.valid_discharge && (avg_uv > standby_lim);
    assign learn_drop = low_rise && s_reg.st.valid_discharge && (avg_uv <= standby_lim);
    assign empty_hit  = !charging && (vbat_mv <= empty_mv);
    assign learn_sum  = add_sat(s_reg.dis_acc,
                                s_reg.learned_full_capacity >> gauge_pkg::REMAIN_SHIFT);
    assign decay_cap  = s_reg.nominal_available_capacity
                        - (s_reg.nominal_available_capacity >> gauge_pkg::DECAY_SHIFT);

    // ****************************************
    // Next-state logic
    // ****************************************
    // Order inside: register port, coulomb flow, self-discharge, full, learning, empty.
    // Empty is last so that a cleared count is never undone by a flow in the same cycle.
    always_comb begin
        logic [15:0] cap_v;
        cap_v = s_reg.nominal_available_capacity;
        s_next = s_reg;
        s_next.nvw.strobe = 1'b0;

        // Register port: unlock, byte writes and the read answer
        if (reg_wr) begin
            if (reg_addr == gauge_pkg::ADDR_UNLOCK) begin
                s_next.unlocked = (reg_wdata == gauge_pkg::UNLOCK_KEY);
            end else if (s_reg.unlocked) begin
                s_next.nvw.strobe = 1'b1;
                s_next.nvw.addr   = reg_addr;
                s_next.nvw.data   = reg_wdata;
                case (reg_addr)
                    gauge_pkg::ADDR_SEED:    s_next.cfg.seed    = reg_wdata;
                    gauge_pkg::ADDR_EMPTY:   s_next.cfg.empty   = reg_wdata;
                    gauge_pkg::ADDR_LOW:     s_next.cfg.low     = reg_wdata;
                    gauge_pkg::ADDR_STANDBY: s_next.cfg.standby = reg_wdata;
                    gauge_pkg::ADDR_FILTER:  s_next.cfg.deadband_and_self_discharge = reg_wdata;
                    gauge_pkg::ADDR_TAPER:   s_next.cfg.taper   = reg_wdata;
                    default:                 s_next.nvw.strobe  = 1'b0;
                endcase
            end
        end
        case (reg_addr)
            gauge_pkg::ADDR_SEED:    s_next.rdata = s_reg.cfg.seed;
            gauge_pkg::ADDR_EMPTY:   s_next.rdata = s_reg.cfg.empty;
            gauge_pkg::ADDR_LOW:     s_next.rdata = s_reg.cfg.low;
            gauge_pkg::ADDR_STANDBY: s_next.rdata = s_reg.cfg.standby;
            gauge_pkg::ADDR_FILTER:  s_next.rdata = s_reg.cfg.deadband_and_self_discharge;
            gauge_pkg::ADDR_TAPER:   s_next.rdata = s_reg.cfg.taper;
            default:                 s_next.rdata = 8'h00;
        endcase

        // Coulomb flow at or above the deadband moves the count
        if (flow_hit) begin
            if (flow.charge) begin
                cap_v = add_sat(cap_v, flow.amount);
            end else begin
                cap_v = sub_floor(cap_v, flow.amount);
                s_next.dis_acc = add_sat(s_reg.dis_acc, flow.amount);
            end
        end

        // Hour time base; the rate accumulator freezes while charging
        s_next.hour_cnt = hour_tick ? '0 : s_reg.hour_cnt + 1'b1;
        if (hour_tick && !charging) begin
            s_next.decay_acc = s_reg.decay_acc + gauge_pkg::DECAY_ACC_W'(weight);
            if (decay_step) begin
                s_next.decay_acc = s_reg.decay_acc + gauge_pkg::DECAY_ACC_W'(weight)
                                   - step_limit;
                cap_v = cap_v - (cap_v >> gauge_pkg::DECAY_SHIFT);
            end
        end

        // Full charge starts a fresh learning discharge
        if (full_hit) begin
            s_next.st.full = 1'b1;
            s_next.st.valid_discharge = 1'b1;
            s_next.dis_acc = 16'h0000;
        end else if (!charging) begin
            s_next.st.full = 1'b0;
        end

        // Low-warning edge either learns or drops the cycle
        if (charging) begin
            s_next.st.low_warning = 1'b0;
            s_next.st.empty = 1'b0;
        end else if (low_hit) begin
            s_next.st.low_warning = 1'b1;
        end
        if (learn_ok) begin
            s_next.learned_full_capacity = learn_sum;
            s_next.st.valid_discharge = 1'b0;
            s_next.st.capacity_inaccurate = 1'b0;
        end else if (learn_drop) begin
            s_next.st.valid_discharge = 1'b0;
        end

        // Empty level clears the available count
        if (empty_hit) begin
            s_next.st.empty = 1'b1;
            cap_v = 16'h0000;
        end
        s_next.nominal_available_capacity = cap_v;

        // Synchronous reset reloads storage and seeds the learned capacity
        if (reset) begin
            s_next = '0;
            s_next.cfg = nv_cfg;
            s_next.learned_full_capacity = {nv_cfg.seed, gauge_pkg::SEED_LOW_BYTE};
            s_next.st.capacity_inaccurate = 1'b1;
        end
    end

    // Single state register
    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    // Outputs straight from the state flops
    assign reg_rdata = s_reg.rdata;
    assign nominal_available_capacity = s_reg.nominal_available_capacity;
    assign learned_full_capacity      = s_reg.learned_full_capacity;
    assign status    = s_reg.st;
    assign nv_write  = s_reg.nvw;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Reset seeds capacity and loads stored bytes
    seed_on_reset_a: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> (s_reg.learned_full_capacity == {$past(nv_cfg.seed), 8'h00})
                  && (s_reg.cfg == $past(nv_cfg)))
        else $error("seed or stored bytes not loaded at reset");

    // Empty voltage marks empty and clears the count
    empty_clears_count_a: assert property (
        (!charging && vbat_mv <= ({8'h00, s_reg.cfg.empty} + 16'd256) * 16'd8)
        |=> s_reg.st.empty && (s_reg.nominal_available_capacity == 16'h0000))
        else $error("empty level did not clear count");

    // Low-warning level raises its flag
    low_flag_set_a: assert property (
        (!charging && vbat_mv <= ({8'h00, s_reg.cfg.low} + 16'd256) * 16'd8)
        |=> s_reg.st.low_warning)
        else $error("low warning flag not set");

    // Qualified learning loads discharge plus remainder
    learn_update_a: assert property (
        learn_ok |=> (s_reg.learned_full_capacity == $past(learn_sum))
                     && !s_reg.st.valid_discharge)
        else $error("learned capacity not updated");

    // Light load at the edge drops learning
    standby_drop_a: assert property (
        (low_rise && s_reg.st.valid_discharge && avg_uv <= 16'(s_reg.cfg.standby) * 16'd12)
        |=> !s_reg.st.valid_discharge && $stable(s_reg.learned_full_capacity))
        else $error("light load did not disqualify learning");

    // Flow under the deadband leaves the count
    deadband_hold_a: assert property (
        (flow.valid && flow.sense_uv < 16'(filter_byte[7:4]) * 16'd6
         && !hour_tick && !empty_hit) |=> $stable(s_reg.nominal_available_capacity))
        else $error("flow inside deadband moved count");

    // No self-discharge while charging
    no_decay_charging_a: assert property (
        (charging && hour_tick) |=> $stable(s_reg.decay_acc))
        else $error("self-discharge advanced while charging");

    // Temperature band weights
    ref_band_a: assert property (
        (temp_c >= 8'sd20 && temp_c < 8'sd30) |-> weight == 7'd4)
        else $error("reference band weight wrong");
    hot_band_a: assert property (
        (temp_c >= 8'sd60) |-> weight == 7'd64)
        else $error("hot band weight wrong");
    cold_band_a: assert property (
        (temp_c < 8'sd0) |-> weight == 7'd1)
        else $error("cold band weight wrong");

    // A lone step takes a 512th
    decay_step_size_a: assert property (
        (decay_step && !flow.valid && !empty_hit)
        |=> s_reg.nominal_available_capacity == $past(decay_cap))
        else $error("self-discharge step size wrong");

    // Code 12 interval is 24 reference hours
    decay_interval_a: assert property (
        (self_discharge_code == 4'd12) |-> step_limit == 8'd96)
        else $error("self-discharge interval wrong");

    // Taper detection sets full
    full_detect_a: assert property (
        (charging && vbat_mv >= CHARGE_FULL_MV && charge_uv < 16'(s_reg.cfg.taper) * 16'd192)
        |=> s_reg.st.full && s_reg.st.valid_discharge)
        else $error("full charge not detected");

    // Learned capacity moves only on a qualified edge
    learn_only_a: assert property (
        (!$past(reset) && $changed(s_reg.learned_full_capacity)) |-> $past(learn_ok))
        else $error("learned capacity changed without learning");

    // Locked writes never touch the bytes
    locked_write_a: assert property (
        (reg_wr && !s_reg.unlocked && reg_addr != 7'h6e) |=> $stable(s_reg.cfg))
        else $error("locked write changed configuration");

    // Unlocked writes land and are handed to storage
    unlocked_write_a: assert property (
        (reg_wr && s_reg.unlocked && reg_addr == 7'h79)
        |=> (s_reg.cfg.standby == $past(reg_wdata)) && s_reg.nvw.strobe)
        else $error("unlocked write did not land");

endmodule

// file: rtl/gauge_pkg.sv
// Constants, carriers and state layout of the gauge configuration and accounting block
package gauge_pkg;

    // ****************************************
    // Register map and unlock key
    // ****************************************
    localparam logic [6:0] ADDR_UNLOCK  = 7'h6e;
    localparam logic [6:0] ADDR_SEED    = 7'h76;
    localparam logic [6:0] ADDR_EMPTY   = 7'h77;
    localparam logic [6:0] ADDR_LOW     = 7'h78;
    localparam logic [6:0] ADDR_STANDBY = 7'h79;
    localparam logic [6:0] ADDR_FILTER  = 7'h7a;
    localparam logic [6:0] ADDR_TAPER   = 7'h7b;
    localparam logic [7:0] UNLOCK_KEY   = 8'hdd;

    // ****************************************
    // Scaling of configuration bytes
    // ****************************************
    localparam logic [15:0] VOLT_OFFSET     = 16'h0100; // Byte plus 256
    localparam int          VOLT_SHIFT      = 3;        // Times 8 mV
    localparam logic [3:0]  LOW_BYTE_SEED   = 4'h0;
    localparam logic [7:0]  SEED_LOW_BYTE   = 8'h00;
    localparam logic [3:0]  STANDBY_STEP_UV = 4'h6;
    localparam logic [3:0]  DEADBAND_STEP_UV = 4'h6;
    localparam logic [7:0]  TAPER_STEP_UV   = 8'hc0;    // 192 uV per count
    localparam int          FILTER_MSB      = 7;
    localparam int          FILTER_LSB      = 4;
    localparam int          CODE_MSB        = 3;
    localparam int          CODE_LSB        = 0;
    localparam int          DECAY_SHIFT     = 9;        // One 512th per step
    localparam int          REMAIN_SHIFT    = 4;        // 6.25 percent left

    // ****************************************
    // Self-discharge timing and temperature bands
    // ****************************************
    localparam logic [7:0] HOURS_PER_CODE = 8'h02;      // Code 12 gives 24 hours
    localparam logic [6:0] W_QUARTER = 7'h01;
    localparam logic [6:0] W_HALF    = 7'h02;
    localparam logic [6:0] W_REF     = 7'h04;
    localparam logic [6:0] W_X2      = 7'h08;
    localparam logic [6:0] W_X4      = 7'h10;
    localparam logic [6:0] W_X8      = 7'h20;
    localparam logic [6:0] W_X16     = 7'h40;
    localparam logic signed [7:0] T_0  = 8'sd0;
    localparam logic signed [7:0] T_10 = 8'sd10;
    localparam logic signed [7:0] T_20 = 8'sd20;
    localparam logic signed [7:0] T_30 = 8'sd30;
    localparam logic signed [7:0] T_40 = 8'sd40;
    localparam logic signed [7:0] T_50 = 8'sd50;
    localparam logic signed [7:0] T_60 = 8'sd60;
    localparam longint CLK_PERIOD_PS = 4000;
    localparam longint PS_PER_S      = 64'd1000000000000;
    localparam longint HOUR_S        = 3600;
    localparam longint HOUR_CYCLES   = HOUR_S * PS_PER_S / CLK_PERIOD_PS;
    localparam int     HOUR_W        = 40;
    localparam int     DECAY_ACC_W   = 8;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] seed;
        logic [7:0] empty;
        logic [7:0] low;
        logic [7:0] standby;
        logic [7:0] deadband_and_self_discharge;
        logic [7:0] taper;
    } cfg_s;

    typedef struct packed {
        logic        valid;
        logic        charge;
        logic [15:0] amount;
        logic [15:0] sense_uv;
    } flow_s;

    typedef struct packed {
        logic valid_discharge;
        logic low_warning;
        logic empty;
        logic full;
        logic capacity_inaccurate;
    } status_s;

    typedef struct packed {
        logic       strobe;
        logic [6:0] addr;
        logic [7:0] data;
    } nv_write_s;

    typedef struct packed {
        cfg_s                   cfg;
        logic                   unlocked;
        logic [15:0]            nominal_available_capacity;
        logic [15:0]            learned_full_capacity;
        logic [15:0]            dis_acc;
        logic [HOUR_W-1:0]      hour_cnt;
        logic [DECAY_ACC_W-1:0] decay_acc;
        status_s                st;
        logic [7:0]             rdata;
        nv_write_s              nvw;
    } state_s;

endpackage

// file: tb/battery_capacity_config_accounting_tb.sv
// Self-checking bench for the gauge configuration and accounting block
`timescale 1ns/1ps

module battery_capacity_config_accounting_tb;
    // Seed 0x40, empty 3200 mV, low 3400 mV, standby 60 uV, deadband 18 uV code 12, taper 960 uV
    localparam gauge_pkg::cfg_s CFG = {8'h40, 8'h90, 8'ha9, 8'h0a, 8'h3c, 8'h05};
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 charging = 1'b0;
    logic [15:0]          vbat_mv = 16'h0ed8;
    logic [15:0]          avg_uv = 16'h0000;
    logic [15:0]          charge_uv = 16'h0000;
    logic signed [7:0]    temp_c = 8'sd25;
    gauge_pkg::flow_s     flow = '0;
    logic [6:0]           reg_addr;
    logic                 reg_wr;
    logic [7:0]           reg_wdata;
    logic [7:0]           reg_rdata;
    logic [15:0]          nominal_available_capacity;
    logic [15:0]          learned_full_capacity;
    gauge_pkg::status_s   status;
    gauge_pkg::nv_write_s nv_write;
    int                   mismatches = 0;
    int                   n_compared = 0;
    logic [7:0]           rv;

    gauge_config_accounting #(.HOUR_CYCLES(4)) i_gauge_config_accounting (
        .clk(clk), .reset(reset), .nv_cfg(CFG), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .charging(charging), .vbat_mv(vbat_mv),
        .avg_uv(avg_uv), .charge_uv(charge_uv), .temp_c(temp_c), .flow(flow),
        .nominal_available_capacity(nominal_available_capacity),
        .learned_full_capacity(learned_full_capacity), .status(status), .nv_write(nv_write));
    host_model i_host_model (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Full reset, so every scenario but t_regs starts from the stored image
    task automatic clr();
        @(posedge clk) reset <= 1'b1;
        repeat (11) @(posedge clk);
        reset <= 1'b0;
    endtask

    // One flow pulse, taken at the following edge
    task automatic pulse(input logic c, input logic [15:0] amt, input logic [15:0] s);
        @(posedge clk) flow <= {1'b1, c, amt, s};
        @(posedge clk) flow <= '0;
        #1;
    endtask

    task automatic t_reset();
        clr();
        #1 check(learned_full_capacity, {CFG.seed, 8'h00});
        check(status.capacity_inaccurate, 1'b1);
        for (int i = 0; i < 6; i++) begin
            i_host_model.rd(gauge_pkg::ADDR_SEED + 7'(i), rv);
            check(rv, CFG[47 - 8 * i -: 8]);
        end
        i_host_model.rd(7'h10, rv);
        check(rv, 8'h00);
        i_host_model.rd(gauge_pkg::ADDR_UNLOCK, rv);
        check(rv, 8'h00);
    endtask

    // Locked writes are dropped; unlocked ones land and reach storage
    task automatic t_regs();
        i_host_model.wr(gauge_pkg::ADDR_STANDBY, 8'h55);
        #1 check(nv_write.strobe, 1'b0);
        i_host_model.rd(gauge_pkg::ADDR_STANDBY, rv);
        check(rv, 8'h0a);
        i_host_model.prog(gauge_pkg::ADDR_STANDBY, 8'h0b);
        #1 check(nv_write, {1'b1, 7'h79, 8'h0b});
        i_host_model.wr(gauge_pkg::ADDR_UNLOCK, 8'h00);
        i_host_model.wr(gauge_pkg::ADDR_STANDBY, 8'h0c);
        i_host_model.rd(gauge_pkg::ADDR_STANDBY, rv);
        check(rv, 8'h0b);
    endtask

    // Deadband boundary at 3 steps of 6 uV
    task automatic t_flow();
        clr();
        pulse(1'b1, 16'h0100, 16'h0012);
        check(nominal_available_capacity, 16'h0100);
        pulse(1'b1, 16'h0100, 16'h0011);
        check(nominal_available_capacity, 16'h0100);
    endtask

    // Full detection, discharge, then learning at the low-warning level
    task automatic t_learn(input logic [15:0] avg, input logic upd);
        clr();
        pulse(1'b1, 16'h2000, 16'h0064);
        @(posedge clk) charging <= 1'b1;
        vbat_mv <= 16'h1004;
        charge_uv <= 16'h03c0;
        repeat (2) @(posedge clk);
        #1 check(status.full, 1'b0);
        @(posedge clk) charge_uv <= 16'h03bf;
        repeat (2) @(posedge clk);
        #1 check({status.full, status.valid_discharge}, 2'b11);
        @(posedge clk) charging <= 1'b0;
        vbat_mv <= 16'h0ed8;
        pulse(1'b0, 16'h1000, 16'h0064);
        @(posedge clk) vbat_mv <= 16'h0d48;
        avg_uv <= avg;
        repeat (2) @(posedge clk);
        #1 check(learned_full_capacity, upd ? 16'h1400 : 16'h4000);
        check({status.valid_discharge, status.capacity_inaccurate}, {1'b0, !upd});
        check(status.low_warning, 1'b1);
        @(posedge clk) vbat_mv <= 16'h0c80;
        repeat (2) @(posedge clk);
        #1 check({status.empty, nominal_available_capacity}, {1'b1, 16'h0000});
        @(posedge clk) vbat_mv <= 16'h0ed8;
        avg_uv <= 16'h0000;
    endtask

    // Thirty to thirty-one hours of self-discharge at one temperature
    task automatic t_sd(input logic signed [7:0] t, input int w, input logic chg);
        logic [15:0] e;
        e = 16'hf000;
        clr();
        @(posedge clk) temp_c <= t;
        charging <= chg;
        pulse(1'b1, 16'hf000, 16'h0064);
        repeat (120) @(posedge clk);
        #1;
        repeat (chg ? 0 : (30 * w) / 96) e = e - (e >> 9);
        check(nominal_available_capacity, e);
        @(posedge clk) charging <= 1'b0;
        temp_c <= 8'sd25;
    endtask

    // Hang guard
    initial begin
        #400000;
        mismatches++;
        summarize();
    end

    initial begin
        int tt[8] = '{-5, 5, 15, 25, 35, 45, 55, 65};
        int ww[8] = '{1, 1, 2, 4, 8, 16, 32, 64};
        t_reset();
        t_regs();
        t_flow();
        t_learn(16'h0079, 1'b1);
        t_learn(16'h0078, 1'b0);
        for (int i = 0; i < 8; i++) t_sd(8'(tt[i]), ww[i], 1'b0);
        t_sd(8'sd65, 64, 1'b1);
        summarize();
    end
endmodule

// file: tb/host_model.sv
// Host model that drives the register byte port of the gauge
`timescale 1ns/1ps

module host_model (
    input  wire logic       clk,
    output logic [6:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // Idle port at time zero
    initial begin
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // One strobe, held up to the edge that takes it
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d; // Stale data is inverted so it cannot pass by chance
    endtask

    // Unlock first, since byte writes are dropped while locked
    task automatic prog(input logic [6:0] a, input logic [7:0] d);
        wr(gauge_pkg::ADDR_UNLOCK, gauge_pkg::UNLOCK_KEY);
        wr(a, d);
    endtask

    // Read data is registered one edge after the address
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
endmodule
